// File: pkg/hsl_pkg.sv
package hsl_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SELFTEST_SEC    = 10;
  localparam int unsigned SELFTEST_CYC    = SELFTEST_SEC * CLK_HZ;
  localparam int unsigned LONG_HALF_MS    = 500;
  localparam int unsigned SHORT_HALF_MS   = 100;
  localparam int unsigned LONG_HALF_CYC   = LONG_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned SHORT_HALF_CYC  = SHORT_HALF_MS * (CLK_HZ / 1000);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MK = 8'h0C;
  localparam logic [7:0] OFS_LONG   = 8'h10;
  localparam logic [7:0] OFS_SHORT  = 8'h14;

  // ctrl field positions
  localparam int unsigned CTRL_ACT_LOCK   = 0;
  localparam int unsigned CTRL_DEACT_LOCK = 1;
  localparam int unsigned CTRL_ACT_GRANT  = 2;
  localparam int unsigned CTRL_DEACT_GRANT = 3;
  localparam int unsigned CTRL_OOS        = 4;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;

  // irq bit positions
  localparam int unsigned IRQ_ACT_REQ   = 0;
  localparam int unsigned IRQ_DEACT_REQ = 1;
  localparam int unsigned IRQ_HS_EVT    = 2;
  localparam int unsigned IRQ_ST_DONE   = 3;
  localparam int unsigned IRQ_W         = 4;

  typedef enum logic [1:0] {
    LATCH_IN  = 2'b00,
    LATCH_HW  = 2'b01,
    LATCH_OUT = 2'b10
  } hsl_latch_t;

  typedef enum {
    ST_SELFTEST,
    FRU_INACTIVE_STATE,
    ACTIVATION_REQUEST_STATE,
    PAYLOAD_ACTIVE_STATE,
    DEACTIVATION_REQUEST_STATE
  } hsl_state_t;

  typedef struct packed {
    logic blue;
    logic red;
    logic green;
  } hsl_leds_t;

endpackage

// File: rtl/hsl_blink.sv
`timescale 1ns/10ps
module hsl_blink
  import hsl_pkg::*;
#(
  parameter int unsigned CW = 32
) (
  // clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_nrst,
  // control
  input  wire logic          i_run,
  input  wire logic [CW-1:0] i_half,
  // pattern out
  output logic               o_wave
);
  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r >= i_half - 1'b1) || (i_half == '0);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r  <= '0;
      o_wave <= 1'b0;
    end else if (!i_run) begin
      cnt_r  <= '0;
      o_wave <= 1'b0;
    end else if (wrap) begin
      cnt_r  <= '0;
      o_wave <= ~o_wave;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end
endmodule

// File: rtl/hsl_apb_regs.sv
`timescale 1ns/10ps
module hsl_apb_regs
  import hsl_pkg::*;
#(
  parameter int unsigned AW = 8
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // apb
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [AW-1:0]     i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // block side
  input  wire logic [31:0]       i_status,
  input  wire logic [IRQ_W-1:0]  i_evt,
  output logic [31:0]            o_ctrl,
  output logic [31:0]            o_long,
  output logic [31:0]            o_short,
  output logic                   o_irq
);
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] imk_r;

  wire acc     = i_psel && i_penable;
  wire wr      = acc && i_pwrite;
  wire hit_ct  = (i_paddr == OFS_CTRL);
  wire hit_st  = (i_paddr == OFS_STATUS);
  wire hit_is  = (i_paddr == OFS_IRQ_ST);
  wire hit_im  = (i_paddr == OFS_IRQ_MK);
  wire hit_lg  = (i_paddr == OFS_LONG);
  wire hit_sh  = (i_paddr == OFS_SHORT);
  wire mapped  = hit_ct | hit_st | hit_is | hit_im | hit_lg | hit_sh;
  wire [IRQ_W-1:0] w1c = (wr && hit_is) ? i_pwdata[IRQ_W-1:0] : '0;
  wire [31:0] rd =
    hit_ct ? o_ctrl :
    hit_st ? i_status :
    hit_is ? {{(32-IRQ_W){1'b0}}, ist_r} :
    hit_im ? {{(32-IRQ_W){1'b0}}, imk_r} :
    hit_lg ? o_long :
    hit_sh ? o_short : 32'h0000_0000;

  // grant bits self-clear, so software pulses them
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ctrl  <= CTRL_RST;
      o_long  <= LONG_HALF_CYC;
      o_short <= SHORT_HALF_CYC;
      imk_r   <= '0;
    end else begin
      o_ctrl[CTRL_ACT_GRANT]   <= 1'b0;
      o_ctrl[CTRL_DEACT_GRANT] <= 1'b0;
      if (wr && hit_ct) o_ctrl <= i_pwdata;
      if (wr && hit_lg) o_long <= i_pwdata;
      if (wr && hit_sh) o_short <= i_pwdata;
      if (wr && hit_im) imk_r <= i_pwdata[IRQ_W-1:0];
    end
  end

  // set wins over write-one-clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ist_r     <= '0;
      o_irq     <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      ist_r     <= (ist_r & ~w1c) | i_evt;
      o_irq     <= |(((ist_r & ~w1c) | i_evt) & imk_r);
      o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd : o_prdata;
      o_pslverr <= i_psel && !i_penable && !mapped;
    end
  end
endmodule

// File: rtl/hsl_sequencer.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
// What this block does
// - solid blue when safe to extract
// - blue dark while card is operational
// - long blink activating, short blink deactivating
// - red on while out of service
// - green on when running, off without payload
// - stay inactive while latch open or locked
// - latch closed and unlocked requests activation
// - activation grant enables payload, blue off
// - latch open or unlock requests deactivation
// - latch in reports no hot-swap state
// - half-way latch raises hot-swap event
// - ten second self-test, ten second blink if passed, then solid
module hsl_sequencer
  import hsl_pkg::*;
#(
  parameter int unsigned SELFTEST_CYCLES = SELFTEST_CYC
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // card inputs
  input  wire logic [1:0]        i_latch,
  input  wire logic              i_payload_pwr,
  input  wire logic              i_payload_booted,
  input  wire logic              i_selftest_ok,
  // card outputs
  output hsl_leds_t              o_leds,
  output logic                   o_payload_en,
  output logic                   o_hot_swap,
  output logic                   o_irq
);
  hsl_state_t    st_r;
  hsl_state_t    st_nxt;
  logic [31:0]   tmr_r;
  logic [1:0]    latch_r;
  logic          st_done_r;
  logic          st_pass_r;
  logic [31:0]   ctrl;
  logic [31:0]   long_half;
  logic [31:0]   short_half;
  logic          wave_long;
  logic          wave_short;
  logic [IRQ_W-1:0] evt;
  hsl_leds_t     leds_nxt;

  wire act_lock   = ctrl[CTRL_ACT_LOCK];
  wire deact_lock = ctrl[CTRL_DEACT_LOCK];
  wire act_gnt    = ctrl[CTRL_ACT_GRANT];
  wire deact_gnt  = ctrl[CTRL_DEACT_GRANT];
  wire latch_in   = (i_latch == LATCH_IN);
  wire to_hw      = (i_latch == LATCH_HW) && (latch_r != LATCH_HW);
  wire st_end     = (tmr_r >= SELFTEST_CYCLES - 1);
  wire in_act_req = (st_r == ACTIVATION_REQUEST_STATE);
  wire in_dea_req = (st_r == DEACTIVATION_REQUEST_STATE);
  wire in_active  = (st_r == PAYLOAD_ACTIVE_STATE);
  wire in_service = in_active && i_payload_pwr && !ctrl[CTRL_OOS];
  wire [31:0] status = {26'h000_0000, st_pass_r, o_payload_en, o_hot_swap,
                        i_latch, i_payload_pwr};

  hsl_apb_regs #(
    .AW (8)
  ) u_regs (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr),
    .i_status  (status),
    .i_evt     (evt),
    .o_ctrl    (ctrl),
    .o_long    (long_half),
    .o_short   (short_half),
    .o_irq     (o_irq)
  );

  hsl_blink #(
    .CW (32)
  ) u_long (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (in_act_req || (st_r == ST_SELFTEST && st_pass_r)),
    .i_half (long_half),
    .o_wave (wave_long)
  );

  hsl_blink #(
    .CW (32)
  ) u_short (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (in_dea_req),
    .i_half (short_half),
    .o_wave (wave_short)
  );

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_SELFTEST: begin
        if (st_done_r) st_nxt = FRU_INACTIVE_STATE;
      end
      FRU_INACTIVE_STATE: begin
        if (latch_in && !act_lock) st_nxt = ACTIVATION_REQUEST_STATE;
      end
      ACTIVATION_REQUEST_STATE: begin
        if (!latch_in || act_lock) st_nxt = FRU_INACTIVE_STATE;
        else if (act_gnt) st_nxt = PAYLOAD_ACTIVE_STATE;
      end
      PAYLOAD_ACTIVE_STATE: begin
        if (!latch_in || !deact_lock) st_nxt = DEACTIVATION_REQUEST_STATE;
      end
      DEACTIVATION_REQUEST_STATE: begin
        if (deact_gnt) st_nxt = FRU_INACTIVE_STATE;
      end
    endcase
  end

  always_comb begin
    leds_nxt = '0;
    unique case (st_r)
      ST_SELFTEST:                leds_nxt.blue = st_pass_r ? wave_long : 1'b1;
      FRU_INACTIVE_STATE:         leds_nxt.blue = 1'b1;
      ACTIVATION_REQUEST_STATE:   leds_nxt.blue = ~wave_long;
      PAYLOAD_ACTIVE_STATE:       leds_nxt.blue = 1'b0;
      DEACTIVATION_REQUEST_STATE: leds_nxt.blue = wave_short;
    endcase
    leds_nxt.red   = ctrl[CTRL_OOS] || !i_payload_pwr || !in_active;
    // green only when booted with power
    leds_nxt.green = i_payload_pwr && i_payload_booted && in_active;
  end

  assign evt[IRQ_HS_EVT]    = to_hw;
  assign evt[IRQ_ACT_REQ]   = (st_nxt == ACTIVATION_REQUEST_STATE) && !in_act_req;
  assign evt[IRQ_DEACT_REQ] = (st_nxt == DEACTIVATION_REQUEST_STATE) && !in_dea_req;
  assign evt[IRQ_ST_DONE]   = (st_r == ST_SELFTEST) && st_end && !st_done_r;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tmr_r     <= 32'h0000_0000;
      st_done_r <= 1'b0;
      st_pass_r <= 1'b0;
    end else if (st_r == ST_SELFTEST && !st_done_r) begin
      tmr_r <= tmr_r + 1'b1;
      if (st_end) begin
        if (st_pass_r || !i_selftest_ok) st_done_r <= 1'b1;
        st_pass_r <= i_selftest_ok;
        tmr_r     <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r         <= ST_SELFTEST;
      latch_r      <= LATCH_OUT;
      o_leds       <= '{blue: 1'b1, red: 1'b1, green: 1'b0};
      o_payload_en <= 1'b0;
      o_hot_swap   <= 1'b1;
      o_pready     <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      latch_r      <= i_latch;
      o_leds       <= leds_nxt;
      o_payload_en <= (st_nxt == PAYLOAD_ACTIVE_STATE);
      o_hot_swap   <= !latch_in;
      o_pready     <= i_psel && !i_penable;
    end
  end

  chk_payload_only_active: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    o_payload_en |-> st_r == PAYLOAD_ACTIVE_STATE)
    else $error("payload enabled outside active");

  chk_blue_dark_active: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == PAYLOAD_ACTIVE_STATE ##1 st_r == PAYLOAD_ACTIVE_STATE |-> !o_leds.blue)
    else $error("blue lit while active");

  chk_blue_solid_idle: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $past(st_r) == FRU_INACTIVE_STATE |-> o_leds.blue)
    else $error("blue not solid when inactive");

  chk_green_no_power: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    !$past(i_payload_pwr) |-> !o_leds.green)
    else $error("green on without payload power");

  chk_red_oos: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $past(ctrl[CTRL_OOS]) |-> o_leds.red)
    else $error("red off while out of service");

  chk_act_request: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == FRU_INACTIVE_STATE && latch_in && !act_lock
      |=> st_r == ACTIVATION_REQUEST_STATE)
    else $error("no activation request");

  chk_stay_inactive: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == FRU_INACTIVE_STATE && act_lock |=> st_r == FRU_INACTIVE_STATE)
    else $error("left inactive while locked");

  chk_grant_active: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    in_act_req && latch_in && !act_lock && act_gnt |=> in_active ##1 o_payload_en)
    else $error("grant did not activate payload");

  chk_deact_req: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    in_active && !latch_in |=> in_dea_req)
    else $error("latch open did not request deactivation");

  chk_hs_event: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    to_hw |=> u_regs.ist_r[IRQ_HS_EVT])
    else $error("half-way event not latched");

  chk_hs_flag: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    latch_in |=> !o_hot_swap)
    else $error("hot-swap flag with latch in");

  chk_long_parked: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    !in_act_req && st_r != ST_SELFTEST |=> !wave_long)
    else $error("long blink running outside its states");

  chk_short_parked: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    !in_dea_req |=> !wave_short)
    else $error("short blink running outside deactivation request");

  chk_deact_exit: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    in_dea_req && deact_gnt |=> st_r == FRU_INACTIVE_STATE && !o_payload_en)
    else $error("deactivation grant did not end in inactive");

  chk_stay_unlatched: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == FRU_INACTIVE_STATE && !latch_in |=> st_r == FRU_INACTIVE_STATE)
    else $error("left inactive with latch open");

  chk_selftest_hold: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == ST_SELFTEST && !st_done_r |=> st_r == ST_SELFTEST)
    else $error("self-test left before it finished");

  chk_selftest_span: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == ST_SELFTEST && !st_done_r && tmr_r < SELFTEST_CYCLES - 1 |=> !st_done_r)
    else $error("self-test ended early");

  chk_blue_solid_test: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == ST_SELFTEST && !st_pass_r |=> o_leds.blue)
    else $error("blue not solid during self-test");

  chk_selftest_exit: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    st_r == ST_SELFTEST && st_done_r |=> st_r == FRU_INACTIVE_STATE)
    else $error("self-test did not hand over to inactive");

  chk_act_from_solid: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(in_act_req) |=> o_leds.blue)
    else $error("activation blink did not start from solid");

  chk_deact_from_off: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(in_dea_req) |=> !o_leds.blue)
    else $error("deactivation blink did not start from off");

  chk_green_active_only: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    o_leds.green |-> $past(in_active))
    else $error("green lit outside active");

  chk_red_not_active: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    !$past(in_active) |-> o_leds.red)
    else $error("red off while out of service");

  chk_red_in_service: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $past(in_service) |-> !o_leds.red)
    else $error("red lit while in service");

  chk_green_booted: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $past(in_active) && $past(i_payload_pwr) && $past(i_payload_booted) |-> o_leds.green)
    else $error("green dark while booted and active");

  chk_hs_raised: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    !latch_in |=> o_hot_swap)
    else $error("hot-swap flag low with latch out");

  chk_act_req_irq: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(in_act_req) |-> u_regs.ist_r[IRQ_ACT_REQ])
    else $error("activation request not flagged");

  chk_deact_req_irq: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(in_dea_req) |-> u_regs.ist_r[IRQ_DEACT_REQ])
    else $error("deactivation request not flagged");

  chk_active_hold: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    in_active && latch_in && deact_lock |=> in_active)
    else $error("left active without cause");

  chk_deact_wait: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    in_dea_req && !deact_gnt |=> in_dea_req)
    else $error("left deactivation request without grant");
endmodule

// File: tb/hsl_card_model.sv
`timescale 1ns/10ps
module hsl_card_model (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // from the block
  input  wire logic i_payload_en,
  // to the block
  output logic      o_payload_pwr,
  output logic      o_payload_booted
);
  logic [3:0] age_r;

  // payload rail rises two cycles after enable, boot ends four later
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      age_r <= 4'h0;
    end else if (!i_payload_en) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end

  assign o_payload_pwr    = (age_r >= 4'h2);
  assign o_payload_booted = (age_r >= 4'h6);
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  import hsl_pkg::*;
  logic        mclk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  latch;
  logic        pay_pwr;
  logic        pay_boot;
  logic        st_ok;
  hsl_leds_t   leds;
  logic        pay_en;
  logic        hot_swap;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          miscompares;
  int          total_checks;

  hsl_sequencer #(.SELFTEST_CYCLES(20)) i_hsl_sequencer (
    .i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_latch(latch),
    .i_payload_pwr(pay_pwr), .i_payload_booted(pay_boot), .i_selftest_ok(st_ok),
    .o_leds(leds), .o_payload_en(pay_en), .o_hot_swap(hot_swap), .o_irq(irq));

  hsl_card_model i_hsl_card_model (
    .i_mclk(mclk), .i_nrst(nrst), .i_payload_en(pay_en),
    .o_payload_pwr(pay_pwr), .o_payload_booted(pay_boot));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // outputs read right after the edge hold their pre-edge values
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask

  task automatic blinks(input int k, output int c);
    logic p;
    c = 0;
    p = leds.blue;
    repeat (k) begin
      @(posedge mclk);
      if (leds.blue !== p) c++;
      p = leds.blue;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(3000);
    miscompares++;
    conclude();
  end

  initial begin
    miscompares = 0;
    total_checks = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    latch = LATCH_OUT;
    st_ok = 1'b1;
    cyc(20);
    `CHK("blue", 1'b1, leds.blue)
    `CHK("green", 1'b0, leds.green)
    `CHK("pay_en", 1'b0, pay_en)
    nrst <= 1'b1;
    apb(1'b1, OFS_LONG, 32'h0000_0004);
    apb(1'b1, OFS_SHORT, 32'h0000_0002);
    apb(1'b1, OFS_IRQ_MK, 32'h0000_000F);
    cyc(10);
    blinks(18, n);
    `CHK("selftest blink", 1'b1, n >= 2)
    cyc(12);
    rdchk(OFS_IRQ_ST, 32'h0000_0008, "irq st");
    `CHK("irq", 1'b1, irq)
    rdchk(OFS_STATUS, 32'h0000_002C, "status");
    rdchk(OFS_CTRL, CTRL_RST, "ctrl");
    apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("test selftest done");
    blinks(12, n);
    `CHK("blue steady", 0, n)
    latch <= LATCH_IN;
    cyc(4);
    `CHK("blue locked", 1'b1, leds.blue)
    `CHK("hot_swap in", 1'b0, hot_swap)
    `CHK("red idle", 1'b1, leds.red)
    `CHK("pay_en idle", 1'b0, pay_en)
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    cyc(4);
    rdchk(OFS_IRQ_ST, 32'h0000_0001, "irq st");
    blinks(24, n);
    `CHK("long blink", 1'b1, n >= 4 && n <= 7)
    $display("test activation request done");
    apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
    apb(1'b1, OFS_CTRL, 32'h0000_0006);
    cyc(10);
    `CHK("pay_en on", 1'b1, pay_en)
    `CHK("blue off", 1'b0, leds.blue)
    `CHK("green on", 1'b1, leds.green)
    `CHK("red off", 1'b0, leds.red)
    apb(1'b1, OFS_CTRL, 32'h0000_0012);
    cyc(2);
    `CHK("red oos", 1'b1, leds.red)
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    cyc(2);
    `CHK("red back", 1'b0, leds.red)
    $display("test active done");
    latch <= LATCH_HW;
    cyc(3);
    `CHK("hot_swap hw", 1'b1, hot_swap)
    rdchk(OFS_IRQ_ST, 32'h0000_0006, "irq st");
    blinks(24, n);
    `CHK("short blink", 1'b1, n >= 8 && n <= 13)
    apb(1'b1, OFS_CTRL, 32'h0000_000A);
    cyc(10);
    `CHK("pay_en off", 1'b0, pay_en)
    `CHK("blue solid", 1'b1, leds.blue)
    `CHK("green off", 1'b0, leds.green)
    // operator pulls the latch only once blue is solid again
    latch <= LATCH_OUT;
    cyc(4);
    `CHK("hot_swap out", 1'b1, hot_swap)
    latch <= LATCH_IN;
    apb(1'b1, OFS_CTRL, 32'h0000_0006);
    apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    rdchk(OFS_IRQ_ST, 32'h0000_0002, "lock deact");
    $display("test deactivation done");
    conclude();
  end
endmodule
